/* rtl/ccs_cpu_clock_select_control.sv */
// CPU clock selection and oscillator control core
//
// How it works
// RL1 - Divide main clock by code, or subsystem by two
// RL2 - Mode bit one passes oscillator, zero halves
// RL3 - Status bit read-only, shows subsystem clock active
// RL4 - Feedback resistor on at zero, off at one
// RL5 - Main oscillator runs at zero, stops at one
// RL6 - Software stops main oscillator by control bit
// RL7 - Software writes zero to control bit three
// RL8 - Reduced variant keeps only the divider bits
// RL9 - Mode write stretches main clock, two periods max
// RL10 - Software writes mode register once after reset
// RL11 - No-halving variant needs mode bit set early
// RL12 - Reset clears the mode register to zero
// RL13 - Shortest instruction spans two CPU clocks
// RL14 - Software zeroes unused extra select bits
// RL15 - Reset values give slowest main CPU clock
// RL16 - Software avoids divider change entering subsystem
// RL17 - Prohibited codes leave selected clock unchanged
// RL18 - Status changes only when switchover completes
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
module ccs_cpu_clock_select_control import ccs_pkg::*; #(
	parameter bit REDUCED = 1'b0
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [CCS_ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic main_osc_tick,
	input wire logic sub_osc_tick,
	output logic main_osc_stop,
	output logic sub_feedback_resistor_off,
	output logic cpu_clock_status,
	output logic main_clock_tick,
	output logic cpu_clock_tick,
	output logic instr_tick
);
	ccs_reg_if regs ();

	logic subsystem_clock_select_q;
	logic [2:0] cpu_divider_q;
	logic main_clock_halving_off_q;
	logic active_sub_q;
	logic [2:0] active_div_q;
	ccs_sw_state_t state_q;
	logic phase_q;
	logic ctl_wr;
	logic mode_wr;
	logic new_sub;
	logic [2:0] new_div;
	logic code_ok;
	logic fx_gated;
	logic fxx_tick;
	logic main_cpu_tick;
	logic sub_half_tick;
	logic cpu_tick;
	logic target_tick;
	logic apply;

	ccs_avmm_slave u_slave (
		.clock(clock),
		.reset(reset),
		.address(address),
		.read(read),
		.write(write),
		.writedata(writedata),
		.byteenable(byteenable),
		.readdata(readdata),
		.waitrequest(waitrequest),
		.regs(regs)
	);

	assign ctl_wr = regs.wr && (regs.idx == CCS_CPU_CLOCK_CONTROL_IDX);
	assign mode_wr = regs.wr && (regs.idx == CCS_OSC_MODE_SELECT_IDX);
	assign new_sub = REDUCED ? 1'b0 : regs.wdata[CCS_SUB_SEL_BIT];
	assign new_div = regs.wdata[CCS_DIV_MSB:0];
	assign code_ok = ccs_code_legal(new_div);

	// Stopped oscillator delivers no ticks
	assign fx_gated = main_osc_tick && !main_osc_stop; // RL5

	// Main system clock, restarted by every mode write
	ccs_tick_div #(
		.SEL_W(1)
	) u_fxx_div (
		.clock(clock),
		.reset(reset),
		.tick_in(fx_gated),
		.clear(mode_wr), // RL9
		.sel(~main_clock_halving_off_q), // RL2
		.tick_out(fxx_tick)
	);

	// CPU clock from main system clock
	ccs_tick_div #(
		.SEL_W(CCS_CPU_DIV_SEL_W)
	) u_cpu_div (
		.clock(clock),
		.reset(reset),
		.tick_in(fxx_tick),
		.clear(apply),
		.sel(active_div_q), // RL1
		.tick_out(main_cpu_tick)
	);

	// Half subsystem oscillator
	ccs_tick_div #(
		.SEL_W(1)
	) u_sub_div (
		.clock(clock),
		.reset(reset),
		.tick_in(sub_osc_tick),
		.clear(1'b0),
		.sel(1'b1),
		.tick_out(sub_half_tick)
	);

	assign cpu_tick = active_sub_q ? sub_half_tick : main_cpu_tick; // RL1
	assign target_tick = subsystem_clock_select_q ? sub_half_tick : fxx_tick;
	assign apply = (state_q == CCS_SW_PEND) && target_tick; // RL18

	// Control register fields
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			main_osc_stop <= CCS_CPU_CLOCK_CONTROL_RST[CCS_MAIN_OSC_STOP_BIT]; // RL15
			sub_feedback_resistor_off <= CCS_CPU_CLOCK_CONTROL_RST[CCS_FEEDBACK_OFF_BIT];
		end else if (ctl_wr && !REDUCED) begin
			main_osc_stop <= regs.wdata[CCS_MAIN_OSC_STOP_BIT]; // RL5
			sub_feedback_resistor_off <= regs.wdata[CCS_FEEDBACK_OFF_BIT]; // RL4
		end
	end

	// Requested clock selection, prohibited codes ignored
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			subsystem_clock_select_q <= CCS_CPU_CLOCK_CONTROL_RST[CCS_SUB_SEL_BIT];
			cpu_divider_q <= CCS_CPU_CLOCK_CONTROL_RST[CCS_DIV_MSB:0]; // RL15
		end else if (ctl_wr && code_ok) begin // RL17
			subsystem_clock_select_q <= new_sub; // RL8
			cpu_divider_q <= new_div;
		end
	end

	// Mode register
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			main_clock_halving_off_q <= CCS_OSC_MODE_SELECT_RST[CCS_HALVING_OFF_BIT]; // RL12
		end else if (mode_wr) begin
			main_clock_halving_off_q <= regs.wdata[CCS_HALVING_OFF_BIT]; // RL2
		end
	end

	// Switchover sequencing
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_q <= CCS_SW_IDLE;
		end else begin
			case (state_q)
				CCS_SW_IDLE: begin
					if (ctl_wr && code_ok) begin
						state_q <= CCS_SW_PEND;
					end
				end
				CCS_SW_PEND: begin
					if (apply && !(ctl_wr && code_ok)) begin
						state_q <= CCS_SW_IDLE;
					end
				end
				default: begin
					state_q <= CCS_SW_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			active_sub_q <= CCS_CPU_CLOCK_CONTROL_RST[CCS_SUB_SEL_BIT];
			active_div_q <= CCS_CPU_CLOCK_CONTROL_RST[CCS_DIV_MSB:0];
		end else if (apply) begin // RL18
			active_sub_q <= subsystem_clock_select_q;
			active_div_q <= cpu_divider_q;
		end
	end

	// Registered clock outputs and status
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cpu_clock_status <= 1'b0;
			main_clock_tick <= 1'b0;
			cpu_clock_tick <= 1'b0;
		end else begin
			cpu_clock_status <= active_sub_q; // RL3
			main_clock_tick <= fxx_tick;
			cpu_clock_tick <= cpu_tick;
		end
	end

	// Instruction slot every second CPU clock
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			phase_q <= 1'b0;
			instr_tick <= 1'b0;
		end else begin
			if (cpu_tick) begin
				phase_q <= ~phase_q;
			end
			instr_tick <= cpu_tick && phase_q; // RL13
		end
	end

	// Read decode, bit three always zero, status read-only
	always_comb begin
		regs.rdata = 8'h00;
		if (regs.idx == CCS_CPU_CLOCK_CONTROL_IDX) begin
			regs.rdata[CCS_DIV_MSB:0] = cpu_divider_q;
			if (!REDUCED) begin // RL8
				regs.rdata[CCS_MAIN_OSC_STOP_BIT] = main_osc_stop;
				regs.rdata[CCS_FEEDBACK_OFF_BIT] = sub_feedback_resistor_off;
				regs.rdata[CCS_STATUS_BIT] = cpu_clock_status; // RL3
				regs.rdata[CCS_SUB_SEL_BIT] = subsystem_clock_select_q;
			end
		end else if (regs.idx == CCS_OSC_MODE_SELECT_IDX) begin
			regs.rdata[CCS_HALVING_OFF_BIT] = main_clock_halving_off_q;
		end
	end

	// Checks
	logic boot_q;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			boot_q <= 1'b0;
		end else begin
			boot_q <= 1'b1;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_cpu_tick_source: assert property ( // RL1
		cpu_clock_tick |-> (cpu_clock_status ? $past(sub_osc_tick) : main_clock_tick))
		else $error("cpu tick without selected source");
	a_mode_passes_fx: assert property ( // RL2
		(main_clock_halving_off_q && fx_gated && !mode_wr) |-> fxx_tick)
		else $error("direct mode dropped an oscillator tick");
	a_status_follows: assert property ( // RL3
		$rose(cpu_clock_status) |-> $past(active_sub_q) && $past(state_q, 2) == CCS_SW_PEND)
		else $error("status rose without switchover");
	a_resistor_write: assert property ( // RL4
		(ctl_wr && !REDUCED) |=> sub_feedback_resistor_off == $past(regs.wdata[6]))
		else $error("feedback resistor bit not taken");
	a_osc_stop_gate: assert property ( // RL5
		main_osc_stop |=> !main_clock_tick)
		else $error("main clock ticks while oscillator stopped");
	a_reduced_zero: assert property ( // RL8
		(regs.idx == CCS_CPU_CLOCK_CONTROL_IDX)
			|-> !regs.rdata[3] && (!REDUCED || regs.rdata[7:3] == 5'h00))
		else $error("control register shows unimplemented bits");

	// Oscillator ticks seen since the last mode write
	logic stretch_arm_q;
	logic stretch_seen_q;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			stretch_arm_q <= 1'b0;
			stretch_seen_q <= 1'b0;
		end else if (mode_wr) begin
			stretch_arm_q <= 1'b1;
			stretch_seen_q <= 1'b0;
		end else if (fxx_tick) begin
			stretch_arm_q <= 1'b0;
		end else if (stretch_arm_q && fx_gated) begin
			stretch_seen_q <= 1'b1;
		end
	end

	a_mode_stretch: assert property ( // RL9
		(stretch_arm_q && fx_gated && !mode_wr
			&& (main_clock_halving_off_q || stretch_seen_q)) |-> fxx_tick)
		else $error("main clock stretched beyond two oscillator ticks");
	a_reset_values: assert property ( // RL15
		!boot_q |-> cpu_divider_q == 3'h4 && !subsystem_clock_select_q
			&& !main_clock_halving_off_q && !main_osc_stop)
		else $error("wrong values after reset");
	// CPU clocks since the last instruction slot
	logic [1:0] cpu_count_q;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cpu_count_q <= 2'h0;
		end else if (instr_tick) begin
			cpu_count_q <= 2'h0;
		end else if (cpu_clock_tick && cpu_count_q != 2'h3) begin
			cpu_count_q <= cpu_count_q + 2'h1;
		end
	end

	a_instr_two: assert property ( // RL13
		instr_tick == (cpu_clock_tick && cpu_count_q == 2'h1))
		else $error("instruction slot not on second cpu clock");
	a_bad_code_kept: assert property ( // RL17
		(ctl_wr && !code_ok) |=> $stable(cpu_divider_q) && $stable(subsystem_clock_select_q))
		else $error("prohibited code changed selection");
	a_switch_on_tick: assert property ( // RL18
		$changed(active_sub_q) |-> $past(state_q) == CCS_SW_PEND && $past(target_tick))
		else $error("switchover without target clock tick");

	c_go_subsystem: cover property ($rose(cpu_clock_status));
	c_back_to_main: cover property ($fell(cpu_clock_status));
	c_mode_write: cover property (mode_wr ##1 main_clock_halving_off_q);
	c_bad_code: cover property (ctl_wr && !code_ok);
endmodule : ccs_cpu_clock_select_control

/* rtl/ccs_pkg.sv */
// Constants and types shared by the CPU clock select control block
package ccs_pkg;
	localparam int CCS_ADDR_W = 18;
	localparam int CCS_IDX_W = 16;
	localparam logic [CCS_IDX_W-1:0] CCS_CPU_CLOCK_CONTROL_IDX = 16'hFFFB;
	localparam logic [CCS_IDX_W-1:0] CCS_OSC_MODE_SELECT_IDX = 16'hFFF9;
	localparam int CCS_MAIN_OSC_STOP_BIT = 7;
	localparam int CCS_FEEDBACK_OFF_BIT = 6;
	localparam int CCS_STATUS_BIT = 5;
	localparam int CCS_SUB_SEL_BIT = 4;
	localparam int CCS_DIV_MSB = 2;
	localparam int CCS_HALVING_OFF_BIT = 0;
	localparam logic [7:0] CCS_CPU_CLOCK_CONTROL_RST = 8'h04;
	localparam logic [7:0] CCS_OSC_MODE_SELECT_RST = 8'h00;
	localparam logic [2:0] CCS_DIV_MAX = 3'h4;
	localparam int CCS_CPU_DIV_SEL_W = 3;
	localparam int CCS_INSTR_CPU_CLOCKS = 2;
	typedef enum logic [0:0] {
		CCS_SW_IDLE = 1'b0,
		CCS_SW_PEND = 1'b1
	} ccs_sw_state_t;
	// Divider code legal for either clock selection
	function automatic logic ccs_code_legal(input logic [2:0] div);
		ccs_code_legal = (div <= CCS_DIV_MAX);
	endfunction : ccs_code_legal
endpackage : ccs_pkg

/* rtl/ccs_reg_if.sv */
// Register access carrier between bus slave and control core
`timescale 1ns/1ps
interface ccs_reg_if;
	import ccs_pkg::*;
	logic wr;
	logic [CCS_IDX_W-1:0] idx;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport bus (output wr, output idx, output wdata, input rdata);
	modport core (input wr, input idx, input wdata, output rdata);
endinterface : ccs_reg_if

/* rtl/ccs_tick_div.sv */
// Power-of-two tick divider with synchronous restart
`timescale 1ns/1ps
module ccs_tick_div import ccs_pkg::*; #(
	parameter int SEL_W = 3
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic tick_in,
	input wire logic clear,
	input wire logic [SEL_W-1:0] sel,
	output logic tick_out
);
	localparam int CNT_W = (1 << SEL_W) - 1;
	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] mask;

	assign mask = ~({CNT_W{1'b1}} << sel);
	assign tick_out = tick_in && (count_q == mask) && !clear;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			count_q <= '0;
		end else if (clear) begin
			count_q <= '0;
		end else if (tick_in) begin
			count_q <= (count_q == mask) ? '0 : count_q + 1'b1;
		end
	end
endmodule : ccs_tick_div

/* rtl/ccs_avmm_slave.sv */
// Avalon-MM slave front end with one wait cycle per access
`timescale 1ns/1ps
module ccs_avmm_slave import ccs_pkg::*; (
	input wire logic clock,
	input wire logic reset,
	input wire logic [CCS_ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	ccs_reg_if.bus regs
);
	assign regs.idx = address[CCS_ADDR_W-1:2];
	assign regs.wdata = writedata[7:0];
	assign regs.wr = write && !waitrequest && byteenable[0];

	// Wait drops for one cycle after a request is seen
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			waitrequest <= 1'b1;
		end else if ((read || write) && waitrequest) begin
			waitrequest <= 1'b0;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			readdata <= 32'h0;
		end else if (read && waitrequest) begin
			readdata <= {24'h0, regs.rdata};
		end
	end
endmodule : ccs_avmm_slave

/* tb/tb_top.sv */
// Self-checking bench for the CPU clock select control block
`timescale 1ns/1ps
module tb_top import ccs_pkg::*;;
	logic clock, reset, read, write, main_osc_tick, sub_osc_tick, main_en, sub_en;
	logic [CCS_ADDR_W-1:0] address;
	logic [31:0] writedata, readdata;
	logic [3:0] byteenable;
	logic waitrequest, main_osc_stop, sub_feedback_resistor_off, cpu_clock_status;
	logic main_clock_tick, cpu_clock_tick, instr_tick;
	logic [7:0] rd;
	logic [2:0] mc, sc;
	int errors, checked, n;
	localparam logic [15:0] CTL = CCS_CPU_CLOCK_CONTROL_IDX;
	localparam logic [15:0] MOD = CCS_OSC_MODE_SELECT_IDX;
	ccs_cpu_clock_select_control DUT (.clock(clock), .reset(reset), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .main_osc_tick(main_osc_tick),
		.sub_osc_tick(sub_osc_tick), .main_osc_stop(main_osc_stop),
		.sub_feedback_resistor_off(sub_feedback_resistor_off),
		.cpu_clock_status(cpu_clock_status), .main_clock_tick(main_clock_tick),
		.cpu_clock_tick(cpu_clock_tick), .instr_tick(instr_tick));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Oscillator pulses: main every 2 cycles, subsystem every 8
	always @(posedge clock) begin
		if (reset) begin
			mc <= 3'h0;
			sc <= 3'h0;
			main_osc_tick <= 1'b0;
			sub_osc_tick <= 1'b0;
		end else begin
			mc <= mc + 3'h1;
			sc <= sc + 3'h1;
			main_osc_tick <= main_en && mc[0];
			sub_osc_tick <= sub_en && (sc == 3'h7);
		end
	end
	task check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : check
	task bus(input logic wr, input logic [15:0] idx, input logic [7:0] d, input logic [3:0] be);
		address <= {idx, 2'b00};
		writedata <= {24'h0, d};
		byteenable <= be;
		write <= wr;
		read <= ~wr;
		do begin
			@(posedge clock);
		end while (waitrequest !== 1'b0);
		rd = readdata[7:0];
		write <= 1'b0;
		read <= 1'b0;
		@(posedge clock);
	endtask : bus
	function logic pulse(input int w);
		pulse = (w == 0) ? main_clock_tick : (w == 1) ? cpu_clock_tick : instr_tick;
	endfunction : pulse
	task period(input int w, output int p);
		int k;
		k = 0;
		p = 0;
		do begin
			@(posedge clock);
			k++;
		end while (pulse(w) !== 1'b1 && k < 300);
		do begin
			@(posedge clock);
			p++;
		end while (pulse(w) !== 1'b1 && p < 300);
	endtask : period
	task wait_st(input logic v);
		int k;
		k = 0;
		while (cpu_clock_status !== v && k < 200) begin
			@(posedge clock);
			k++;
		end
	endtask : wait_st
	task t_reset;
		bus(1'b0, CTL, 8'h00, 4'hF);
		check(32'(rd), 32'h04);
		bus(1'b0, MOD, 8'h00, 4'hF);
		check(32'(rd), 32'h00);
		period(0, n);
		check(n, 4);
		period(1, n);
		period(1, n);
		check(n, 64);
		$display("reset test done");
	endtask : t_reset
	task t_regs;
		bus(1'b1, CTL, 8'hF7, 4'hF);
		bus(1'b0, CTL, 8'h00, 4'hF);
		check(32'(rd), 32'hC4);
		check(32'({main_osc_stop, sub_feedback_resistor_off}), 32'h3);
		bus(1'b1, CTL, 8'h00, 4'hE);
		bus(1'b0, CTL, 8'h00, 4'hF);
		check(32'(rd), 32'hC4);
		bus(1'b1, CTL, 8'h00, 4'hF);
		bus(1'b0, CTL, 8'h00, 4'hF);
		check(32'(rd), 32'h00);
		check(32'({main_osc_stop, sub_feedback_resistor_off}), 32'h0);
		bus(1'b1, MOD, 8'hFF, 4'hF);
		bus(1'b0, MOD, 8'h00, 4'hF);
		check(32'(rd), 32'h01);
		bus(1'b0, 16'h0000, 8'h00, 4'hF);
		check(32'(rd), 32'h00);
		$display("register test done");
	endtask : t_regs
	task t_div;
		period(0, n);
		check(n, 2);
		for (int d = 0; d <= 4; d++) begin
			bus(1'b1, CTL, 8'(d), 4'hF);
			period(1, n);
			period(1, n);
			check(n, 2 << d);
			period(2, n);
			period(2, n);
			check(n, 4 << d);
		end
		$display("divider test done");
	endtask : t_div
	task t_sub;
		sub_en <= 1'b0;
		bus(1'b1, CTL, 8'h14, 4'hF);
		repeat (30) @(posedge clock);
		check(32'(cpu_clock_status), 32'h0);
		sub_en <= 1'b1;
		wait_st(1'b1);
		bus(1'b0, CTL, 8'h00, 4'hF);
		check(32'(rd), 32'h34);
		period(1, n);
		period(1, n);
		check(n, 16);
		bus(1'b1, CTL, 8'h94, 4'hF);
		n = 0;
		repeat (40) begin
			@(posedge clock);
			n += int'(main_clock_tick);
		end
		check(n, 0);
		bus(1'b1, CTL, 8'h84, 4'hF);
		repeat (40) @(posedge clock);
		check(32'(cpu_clock_status), 32'h1);
		bus(1'b1, CTL, 8'h02, 4'hF);
		wait_st(1'b0);
		check(32'(cpu_clock_status), 32'h0);
		period(1, n);
		period(1, n);
		check(n, 8);
		$display("subsystem test done");
	endtask : t_sub
	task results;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results
	initial begin
		#300000;
		errors++;
		results();
	end
	initial begin
		errors = 0;
		checked = 0;
		reset = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = '0;
		writedata = '0;
		byteenable = 4'h0;
		main_en = 1'b1;
		sub_en = 1'b1;
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		t_reset();
		t_regs();
		t_div();
		t_sub();
		results();
	end
endmodule : tb_top
